// [common/dcpm_map.svh]
// Constants of the dual clock and power mode controller
`ifndef DCPM_MAP_SVH
`define DCPM_MAP_SVH

// Clock rate and derived timing
`define DCPM_CLK_FREQ_KHZ     25000
`define DCPM_CYCLES_PER_MS    (`DCPM_CLK_FREQ_KHZ * 1)
`define DCPM_WDT_SHORT_MS     7'h0E
`define DCPM_WDT_LONG_MS      7'h79

// Time-base divider
`define DCPM_TB_WIDTH         15
`define DCPM_FOSC_DIV         128
`define DCPM_FDIV_WIDTH       7
`define DCPM_TB_DIV_32768     2'h0
`define DCPM_TB_DIV_16384     2'h1
`define DCPM_TB_DIV_8192      2'h2
`define DCPM_TB_DIV_128       2'h3
`define DCPM_TB_TAP_32768     15'h7FFF
`define DCPM_TB_TAP_16384     15'h3FFF
`define DCPM_TB_TAP_8192      15'h1FFF
`define DCPM_TB_TAP_128       15'h007F

// Clock source field codes
`define DCPM_CLOCK_SOURCE_FIELD_FAST_XTAL   2'h3
`define DCPM_CLOCK_SOURCE_FIELD_SLOW_XTAL   2'h2
`define DCPM_CLOCK_SOURCE_FIELD_FAST_IRC    2'h1
`define DCPM_CLOCK_SOURCE_FIELD_EXT_RC      2'h0

// Slow clock type codes
`define DCPM_SLOW_INT_RC      2'h0
`define DCPM_SLOW_XTAL        2'h1
`define DCPM_SLOW_EXT_RC      2'h2

// Bit positions of the synchronised pin inputs
`define DCPM_SI_FTICK         0
`define DCPM_SI_STICK         1
`define DCPM_SI_FRDY          2
`define DCPM_SI_SRDY          3
`define DCPM_SI_EXT           4
`define DCPM_SI_PBW           5
`define DCPM_SI_COUNT         6

`endif

// [common/dcpm_pkg.sv]
// Types of the dual clock and power mode controller
package dcpm_pkg;

	typedef enum logic [4:0]
	{
		MODE_FAST = 5'h01,
		MODE_SLOW = 5'h02,
		MODE_IDLE = 5'h04,
		MODE_STOP = 5'h08,
		MODE_WAKE = 5'h10
	} dcpm_mode_t;

	typedef enum logic [2:0]
	{
		SRC_FAST_CRYSTAL  = 3'h0,
		SRC_SLOW_CRYSTAL  = 3'h1,
		SRC_EXTERNAL_RC   = 3'h2,
		SRC_SLOW_INT_RC   = 3'h3,
		SRC_FAST_INT_RC   = 3'h4
	} dcpm_src_t;

	typedef struct packed
	{
		logic [1:0] clock_source_field;
		logic [1:0] slow_clock_type_select;
		logic       timebase_clock_select;
		logic [1:0] timebase_divider_select;
		logic       slow_clock_enable;
		logic       slow_clock_select;
		logic       fast_clock_stop;
		logic       watchdog_reset_enable;
		logic       wakeup_interrupt_enable;
		logic       wdt_period_select;
	} dcpm_ctrl_t;

endpackage : dcpm_pkg

// [dv/dcpm_osc_model.sv]
// Behavioural oscillator with start-up delay, stands still when disabled
module dcpm_osc_model #(
	parameter int HALF  = 4,
	parameter int START = 30
) (
	// Clock
	clock,
	// Control
	enable,
	// Oscillator outputs
	tick,
	ready
);
	timeunit 1ns;
	timeprecision 1ns;

	input  wire logic clock;
	input  wire logic enable;
	output logic      tick;
	output logic      ready;

	int cnt;
	int run;

	initial
	begin
		tick = 1'b0;
		ready = 1'b0;
		cnt = 0;
		run = 0;
	end

	// A stopped oscillator gives no edges and drops its ready at once
	always @(negedge clock)
	begin
		if (!enable)
		begin
			tick <= 1'b0;
			ready <= 1'b0;
			cnt <= 0;
			run <= 0;
		end
		else
		begin
			run <= run + 1;
			ready <= (run >= START);
			cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
			if (cnt == HALF - 1)
				tick <= ~tick;
		end
	end
endmodule : dcpm_osc_model

// [dv/dcpm_top_bench.sv]
// Self-checking bench of the dual clock and power mode controller
`define CHK(got, exp) \
	begin \
		n_tests++; \
		if ((got) !== (exp)) \
		begin \
			n_errors++; \
			$display("mismatch at %0t: got %h expected %h", $time, got, exp); \
		end \
	end

module dcpm_top_bench;
	timeunit 1ns;
	timeprecision 1ns;

	logic                 clock;
	logic                 rst_n;
	dcpm_pkg::dcpm_ctrl_t ctrl;
	logic                 sleep_i;
	logic                 wd_clr;
	logic                 tb_clr;
	logic                 wk_clr;
	logic                 f_tick;
	logic                 s_tick;
	logic                 f_rdy;
	logic                 s_rdy;
	logic                 ext_pin;
	logic                 pb_wake;
	logic                 f_en;
	logic                 s_en;
	logic                 wd_en;
	logic                 cpu_tick;
	logic                 per_tick;
	logic                 fetch;
	dcpm_pkg::dcpm_src_t  src;
	dcpm_pkg::dcpm_mode_t mode;
	logic                 tb_flag;
	logic                 wk_flag;
	logic                 chip_rst;
	int                   n_errors = 0;
	int                   n_tests = 0;
	int                   ct;

	dcpm_top #(.WDT_CYCLES_PER_MS(4)) dut_u (
		.clock(clock), .rst_n(rst_n), .ctrl(ctrl),
		.sleep_instruction(sleep_i), .watchdog_clear_instruction(wd_clr),
		.timebase_flag_clear(tb_clr), .wakeup_flag_clear(wk_clr),
		.fast_osc_tick_in(f_tick), .slow_osc_tick_in(s_tick),
		.fast_osc_ready_in(f_rdy), .slow_osc_ready_in(s_rdy),
		.external_pin_interrupt(ext_pin), .port_b_low_level_wake(pb_wake),
		.fast_osc_enable(f_en), .slow_osc_enable(s_en),
		.wdt_osc_enable(wd_en), .cpu_tick(cpu_tick), .periph_tick(per_tick),
		.cpu_fetch_enable(fetch), .cpu_source(src), .power_mode(mode),
		.timebase_interrupt_flag(tb_flag), .wakeup_timer_flag(wk_flag),
		.chip_reset_request(chip_rst));

	dcpm_osc_model #(.HALF(3), .START(30)) fast_u (
		.clock(clock), .enable(f_en), .tick(f_tick), .ready(f_rdy));
	dcpm_osc_model #(.HALF(4), .START(40)) slow_u (
		.clock(clock), .enable(s_en), .tick(s_tick), .ready(s_rdy));

	task test_done;
		if (n_errors == 0 && n_tests > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : test_done

	task wait_cyc(input int n);
		repeat (n) @(negedge clock);
	endtask : wait_cyc

	// One-cycle request pulse: 0 sleep, 1 timer clear, 2 and 3 flag clears
	task pulse(input int which);
		sleep_i = (which == 0);
		wd_clr = (which == 1);
		tb_clr = (which == 2);
		wk_clr = (which == 3);
		@(negedge clock);
		{sleep_i, wd_clr, tb_clr, wk_clr} = 4'h0;
	endtask : pulse

	task wait_mode(input dcpm_pkg::dcpm_mode_t m, input int lim);
		for (int i = 0; i < lim && mode !== m; i++)
			@(negedge clock);
		`CHK(mode, m)
	endtask : wait_mode

	// Watches events for n cycles; also counts peripheral ticks
	task watch(input int n, output bit rs, output bit wk, output int pt);
		rs = 0;
		wk = 0;
		pt = 0;
		ct = 0;
		repeat (n)
		begin
			@(negedge clock);
			rs |= (chip_rst === 1'b1);
			wk |= (wk_flag === 1'b1) || (tb_flag === 1'b1);
			pt += (per_tick === 1'b1);
			ct += (cpu_tick === 1'b1);
		end
	endtask : watch

	logic [1:0]          fsel [3] = '{2'h3, 2'h0, 2'h1};
	dcpm_pkg::dcpm_src_t fsrc [3] = '{dcpm_pkg::SRC_FAST_CRYSTAL,
		dcpm_pkg::SRC_EXTERNAL_RC, dcpm_pkg::SRC_FAST_INT_RC};
	dcpm_pkg::dcpm_src_t ssrc [3] = '{dcpm_pkg::SRC_SLOW_INT_RC,
		dcpm_pkg::SRC_SLOW_CRYSTAL, dcpm_pkg::SRC_EXTERNAL_RC};
	bit                  rs;
	bit                  wk;
	int                  pt;

	initial
	begin
		clock = 1'b0;
		forever #20 clock = ~clock;
	end

	initial
	begin
		#240000;
		n_errors++;
		test_done();
	end

	initial
	begin
		rst_n = 1'b0;
		ctrl = '0;
		{sleep_i, wd_clr, tb_clr, wk_clr, ext_pin, pb_wake} = 6'h00;
		wait_cyc(8);
		rst_n = 1'b1;
		wait_cyc(1);
		`CHK(mode, dcpm_pkg::MODE_FAST)
		`CHK(f_en, 1'b1)
		for (int i = 0; i < 3; i++)
		begin
			ctrl.clock_source_field = fsel[i];
			wait_cyc(4);
			`CHK(src, fsrc[i])
		end
		wait_cyc(40);
		watch(64, rs, wk, pt);
		`CHK(pt inside {[10:11]}, 1'b1)
		`CHK(ct inside {[10:11]}, 1'b1)
		// Fast to slow in the advised order
		ctrl.slow_clock_enable = 1'b1;
		wait_cyc(50);
		ctrl.slow_clock_select = 1'b1;
		wait_mode(dcpm_pkg::MODE_SLOW, 20);
		ctrl.fast_clock_stop = 1'b1;
		wait_cyc(4);
		`CHK(f_en, 1'b0)
		for (int i = 0; i < 3; i++)
		begin
			// Port A pull-up setup for these types is firmware's, not ours
			ctrl.slow_clock_type_select = 2'(i);
			wait_cyc(4);
			`CHK(src, ssrc[i])
		end
		wait_cyc(20);
		watch(64, rs, wk, pt);
		`CHK(pt inside {[7:8]}, 1'b1)
		`CHK(ct inside {[7:8]}, 1'b1)
		// Slow back to fast, leaving the slow oscillator on
		ctrl.fast_clock_stop = 1'b0;
		wait_cyc(45);
		ctrl.slow_clock_select = 1'b0;
		wait_mode(dcpm_pkg::MODE_FAST, 20);
		`CHK(s_en, 1'b1)
		// Idle entry, a second sleep ignored, pin wake
		ctrl.timebase_clock_select = 1'b0;
		pulse(0);
		wait_cyc(2);
		`CHK(mode, dcpm_pkg::MODE_IDLE)
		`CHK({fetch, f_en, s_en}, 3'h1)
		pulse(0);
		wait_cyc(2);
		`CHK(mode, dcpm_pkg::MODE_IDLE)
		ext_pin = 1'b1;
		wait_mode(dcpm_pkg::MODE_FAST, 80);
		`CHK(fetch, 1'b1)
		ext_pin = 1'b0;
		// Stop entry, no clock runs, port B wake
		ctrl.slow_clock_enable = 1'b0;
		wait_cyc(4);
		pulse(0);
		wait_cyc(2);
		`CHK(mode, dcpm_pkg::MODE_STOP)
		`CHK({f_en, s_en, fetch}, 3'h0)
		wait_cyc(200);
		`CHK(mode, dcpm_pkg::MODE_STOP)
		pb_wake = 1'b1;
		wait_mode(dcpm_pkg::MODE_FAST, 80);
		pb_wake = 1'b0;
		// Time-base on the slow clock at the shortest ratio
		ctrl.slow_clock_enable = 1'b1;
		ctrl.timebase_divider_select = 2'h3;
		wait_cyc(50);
		pulse(2);
		wait_cyc(1);
		`CHK(tb_flag, 1'b0)
		watch(1200, rs, wk, pt);
		`CHK(wk, 1'b1)
		pulse(2);
		// Watchdog oscillator gating and wake-up timer
		wait_cyc(4);
		`CHK(wd_en, 1'b0)
		ctrl.wakeup_interrupt_enable = 1'b1;
		wait_cyc(4);
		`CHK(wd_en, 1'b1)
		pulse(1);
		watch(80, rs, wk, pt);
		`CHK({rs, wk_flag}, 2'h1)
		pulse(3);
		wait_cyc(1);
		`CHK(wk_flag, 1'b0)
		// Watchdog reset, held off by a clear in mid-count
		ctrl.watchdog_reset_enable = 1'b1;
		ctrl.wakeup_interrupt_enable = 1'b0;
		pulse(1);
		watch(40, rs, wk, pt);
		pulse(1);
		watch(40, rs, wk, pt);
		`CHK(rs, 1'b0)
		watch(40, rs, wk, pt);
		`CHK(rs, 1'b1)
		// Long period: 121 ms of 4 cycles each
		ctrl.wdt_period_select = 1'b1;
		pulse(1);
		watch(400, rs, wk, pt);
		`CHK(rs, 1'b0)
		watch(100, rs, wk, pt);
		`CHK(rs, 1'b1)
		test_done();
	end
endmodule : dcpm_top_bench

// [src/dcpm_top.sv]
// Dual clock and power mode controller
//
// Function
// RULE1: Reset always starts in fast mode
// RULE2: Fast source follows two-bit source field
// RULE3: Fast mode peripherals fast; time-base selectable
// RULE4: Slow mode picks slow type, fast stopped
// RULE5: Slow mode clocks every peripheral slowly
// RULE6: Sleep with slow enabled enters idle
// RULE7: Sleep with slow disabled enters stop
// RULE8: Firmware: enable, select, then stop fast
// RULE9: Firmware: restart fast, deselect, optionally disable
// RULE10: Slow oscillator may run in fast mode
// RULE11: Firmware: enable slow, time-base slow, sleep
// RULE12: Idle wakes on pin, port, timers
// RULE13: Stop wakes on pin, port, wake timer
// RULE14: Firmware sets port A pull-ups for slow
// RULE15: Time-base is 15 bits, two clocks
// RULE16: Time-base flag at four ratios, unreadable
// RULE17: Shared timer period 14 or 121 ms
// RULE18: Clear instruction resets shared timer
// RULE19: Overflow resets chip or flags wake-up
// RULE20: Sleep stops timer unless wake-up enabled
// RULE21: Normal mode oscillator stops only both off
// RULE22: Only sleep instruction enters power-down
// RULE23: Watchdog enable disables wake-up timer
// RULE24: Source changeover never truncates clock pulses
// RULE25: Wake waits for stable oscillator first
`include "dcpm_map.svh"

module dcpm_top #(
	parameter int unsigned WDT_CYCLES_PER_MS = `DCPM_CYCLES_PER_MS
) (
	// Clock and reset
	input  wire logic               clock,
	input  wire logic               rst_n,
	// Firmware control
	input  dcpm_pkg::dcpm_ctrl_t    ctrl,
	input  wire logic               sleep_instruction,
	input  wire logic               watchdog_clear_instruction,
	input  wire logic               timebase_flag_clear,
	input  wire logic               wakeup_flag_clear,
	// Oscillator and wake pins
	input  wire logic               fast_osc_tick_in,
	input  wire logic               slow_osc_tick_in,
	input  wire logic               fast_osc_ready_in,
	input  wire logic               slow_osc_ready_in,
	input  wire logic               external_pin_interrupt,
	input  wire logic               port_b_low_level_wake,
	// Oscillator control
	output logic                    fast_osc_enable,
	output logic                    slow_osc_enable,
	output logic                    wdt_osc_enable,
	// Clock enables, source and mode to the core
	output logic                    cpu_tick,
	output logic                    periph_tick,
	output logic                    cpu_fetch_enable,
	output dcpm_pkg::dcpm_src_t     cpu_source,
	output dcpm_pkg::dcpm_mode_t    power_mode,
	// Events
	output logic                    timebase_interrupt_flag,
	output logic                    wakeup_timer_flag,
	output logic                    chip_reset_request
);

	function automatic dcpm_pkg::dcpm_src_t fast_src(input logic [1:0] f);
		unique case (f)
			`DCPM_CLOCK_SOURCE_FIELD_FAST_XTAL: fast_src = dcpm_pkg::SRC_FAST_CRYSTAL;
			`DCPM_CLOCK_SOURCE_FIELD_SLOW_XTAL: fast_src = dcpm_pkg::SRC_SLOW_CRYSTAL;
			`DCPM_CLOCK_SOURCE_FIELD_FAST_IRC:  fast_src = dcpm_pkg::SRC_FAST_INT_RC;
			default:              fast_src = dcpm_pkg::SRC_EXTERNAL_RC;
		endcase
	endfunction : fast_src

	function automatic dcpm_pkg::dcpm_src_t slow_src(input logic [1:0] t);
		unique case (t)
			`DCPM_SLOW_XTAL:   slow_src = dcpm_pkg::SRC_SLOW_CRYSTAL;
			`DCPM_SLOW_EXT_RC: slow_src = dcpm_pkg::SRC_EXTERNAL_RC;
			default:           slow_src = dcpm_pkg::SRC_SLOW_INT_RC;
		endcase
	endfunction : slow_src

	function automatic logic [14:0] tb_tap(input logic [1:0] s);
		unique case (s)
			`DCPM_TB_DIV_32768: tb_tap = `DCPM_TB_TAP_32768;
			`DCPM_TB_DIV_16384: tb_tap = `DCPM_TB_TAP_16384;
			`DCPM_TB_DIV_8192:  tb_tap = `DCPM_TB_TAP_8192;
			default:            tb_tap = `DCPM_TB_TAP_128;
		endcase
	endfunction : tb_tap

	// Reset release through two flops
	logic rst_meta_q, rst_sync_n;

	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			rst_meta_q <= 1'h0;
			rst_sync_n <= 1'h0;
		end
		else
		begin
			rst_meta_q <= 1'h1;
			rst_sync_n <= rst_meta_q;
		end
	end

	// Pin synchronisers; a third stage only feeds edge detection
	logic [`DCPM_SI_COUNT-1:0] pins, sync1_q, sync2_q, sync3_q;

	assign pins = {port_b_low_level_wake, external_pin_interrupt,
		slow_osc_ready_in, fast_osc_ready_in,
		slow_osc_tick_in, fast_osc_tick_in};

	genvar gi;
	generate
		for (gi = 0; gi < `DCPM_SI_COUNT; gi++)
		begin : g_sync
			always_ff @(posedge clock or negedge rst_sync_n)
			begin
				if (!rst_sync_n)
				begin
					sync1_q[gi] <= 1'h0;
					sync2_q[gi] <= 1'h0;
					sync3_q[gi] <= 1'h0;
				end
				else
				begin
					sync1_q[gi] <= pins[gi];
					sync2_q[gi] <= sync1_q[gi];
					sync3_q[gi] <= sync2_q[gi];
				end
			end
		end
	endgenerate

	logic fast_edge, slow_edge, fast_rdy, slow_rdy, ext_w, pb_w;

	assign fast_edge = sync2_q[`DCPM_SI_FTICK] & ~sync3_q[`DCPM_SI_FTICK];
	assign slow_edge = sync2_q[`DCPM_SI_STICK] & ~sync3_q[`DCPM_SI_STICK];
	assign fast_rdy = sync2_q[`DCPM_SI_FRDY];
	assign slow_rdy = sync2_q[`DCPM_SI_SRDY];
	assign ext_w = sync2_q[`DCPM_SI_EXT];
	assign pb_w = sync2_q[`DCPM_SI_PBW];

	// Mode, clock selection and time-base state
	dcpm_pkg::dcpm_mode_t mode_q, mode_d;
	dcpm_pkg::dcpm_src_t  src_q, src_d;
	logic        ret_slow_q, ret_slow_d, hold_q, hold_d;
	logic        fosc_q, fosc_d, sosc_q, sosc_d;
	logic        cpu_q, cpu_d, per_q, per_d, fetch_q, fetch_d;
	logic        tbf_q, tbf_d;
	logic [`DCPM_FDIV_WIDTH-1:0] fdiv_q, fdiv_d;
	logic [`DCPM_TB_WIDTH-1:0]   tb_q, tb_d;
	logic        fdiv_tick, tb_tick, tb_hit, new_edge, running;
	logic        wkt_evt, sleeping;

	assign sleeping = (mode_q == dcpm_pkg::MODE_IDLE)
		| (mode_q == dcpm_pkg::MODE_STOP) | (mode_q == dcpm_pkg::MODE_WAKE);

	always_comb
	begin
		mode_d = mode_q;
		ret_slow_d = ret_slow_q;
		unique case (mode_q)
			dcpm_pkg::MODE_FAST:
				if (sleep_instruction) // RULE22
				begin
					ret_slow_d = 1'h0;
					mode_d = ctrl.slow_clock_enable ? dcpm_pkg::MODE_IDLE // RULE6
						: dcpm_pkg::MODE_STOP; // RULE7
				end
				// Firmware enables the slow clock first; the switch still waits for slow_rdy here
				else if (ctrl.slow_clock_select && ctrl.slow_clock_enable
					&& slow_rdy) // RULE8
					mode_d = dcpm_pkg::MODE_SLOW;
			dcpm_pkg::MODE_SLOW:
				if (sleep_instruction) // RULE22
				begin
					ret_slow_d = 1'h1;
					mode_d = ctrl.slow_clock_enable ? dcpm_pkg::MODE_IDLE // RULE6
						: dcpm_pkg::MODE_STOP; // RULE7
				end
				else if ((!ctrl.slow_clock_select || !ctrl.slow_clock_enable)
					&& fast_rdy) // RULE9
					mode_d = dcpm_pkg::MODE_FAST;
			dcpm_pkg::MODE_IDLE:
				if (ext_w || pb_w || wkt_evt || tb_hit) // RULE12
					mode_d = dcpm_pkg::MODE_WAKE;
			dcpm_pkg::MODE_STOP:
				if (ext_w || pb_w || wkt_evt) // RULE13
					mode_d = dcpm_pkg::MODE_WAKE;
			dcpm_pkg::MODE_WAKE:
				if (ret_slow_q ? slow_rdy : fast_rdy) // RULE25
					mode_d = ret_slow_q ? dcpm_pkg::MODE_SLOW
						: dcpm_pkg::MODE_FAST;
			default:
				mode_d = dcpm_pkg::MODE_FAST;
		endcase

		// Blank the CPU clock from a switch through the new source's first edge
		new_edge = (mode_q == dcpm_pkg::MODE_SLOW) ? slow_edge : fast_edge;
		running = ((mode_q == dcpm_pkg::MODE_FAST)
			|| (mode_q == dcpm_pkg::MODE_SLOW)) && (mode_d == mode_q);
		hold_d = hold_q;
		if (mode_d != mode_q)
			hold_d = 1'h1; // RULE24
		else if (new_edge)
			hold_d = 1'h0; // RULE24
		cpu_d = running & ~hold_q & new_edge; // RULE24
		fetch_d = (mode_d == dcpm_pkg::MODE_FAST)
			|| (mode_d == dcpm_pkg::MODE_SLOW);

		src_d = src_q;
		if (mode_q == dcpm_pkg::MODE_FAST)
			src_d = fast_src(ctrl.clock_source_field); // RULE2
		else if (mode_q == dcpm_pkg::MODE_SLOW)
			src_d = slow_src(ctrl.slow_clock_type_select); // RULE4

		fosc_d = (mode_d == dcpm_pkg::MODE_FAST)
			|| ((mode_d == dcpm_pkg::MODE_SLOW) && !ctrl.fast_clock_stop) // RULE4
			|| ((mode_d == dcpm_pkg::MODE_WAKE) && !ret_slow_d); // RULE25
		sosc_d = (((mode_d == dcpm_pkg::MODE_FAST) // RULE10
			|| (mode_d == dcpm_pkg::MODE_IDLE)) && ctrl.slow_clock_enable)
			|| (mode_d == dcpm_pkg::MODE_SLOW)
			|| ((mode_d == dcpm_pkg::MODE_WAKE)
				&& (ret_slow_d || ctrl.slow_clock_enable)); // RULE25

		per_d = 1'h0;
		if (mode_q == dcpm_pkg::MODE_FAST)
			per_d = fast_edge; // RULE3
		else if (mode_q == dcpm_pkg::MODE_SLOW)
			per_d = slow_edge; // RULE5

		// Oscillator divided by 128 exists only in fast mode
		fdiv_tick = (mode_q == dcpm_pkg::MODE_FAST) && fast_edge
			&& (fdiv_q == `DCPM_FDIV_WIDTH'(`DCPM_FOSC_DIV - 1)); // RULE15
		fdiv_d = fdiv_q;
		if ((mode_q == dcpm_pkg::MODE_FAST) && fast_edge)
			fdiv_d = fdiv_q + `DCPM_FDIV_WIDTH'(1);
		unique case (mode_q)
			dcpm_pkg::MODE_FAST:
				tb_tick = ctrl.timebase_clock_select ? fdiv_tick : slow_edge; // RULE3
			dcpm_pkg::MODE_SLOW:
				tb_tick = slow_edge; // RULE5
			dcpm_pkg::MODE_IDLE:
				tb_tick = !ctrl.timebase_clock_select && slow_edge; // RULE6
			default:
				tb_tick = 1'h0; // RULE7
		endcase
		tb_d = tb_tick ? tb_q + `DCPM_TB_WIDTH'(1) : tb_q; // RULE15
		tb_hit = tb_tick
			&& ((tb_q & tb_tap(ctrl.timebase_divider_select))
				== tb_tap(ctrl.timebase_divider_select)); // RULE16
		tbf_d = tb_hit | (tbf_q & ~timebase_flag_clear);
	end

	always_ff @(posedge clock or negedge rst_sync_n)
	begin
		if (!rst_sync_n)
		begin
			mode_q <= dcpm_pkg::MODE_FAST; // RULE1
			src_q <= dcpm_pkg::SRC_EXTERNAL_RC;
			ret_slow_q <= 1'h0;
			hold_q <= 1'h0;
			fosc_q <= 1'h1; // RULE1
			sosc_q <= 1'h0;
			cpu_q <= 1'h0;
			per_q <= 1'h0;
			fetch_q <= 1'h0;
			tbf_q <= 1'h0;
			fdiv_q <= '0;
			tb_q <= '0;
		end
		else
		begin
			mode_q <= mode_d;
			src_q <= src_d;
			ret_slow_q <= ret_slow_d;
			hold_q <= hold_d;
			fosc_q <= fosc_d;
			sosc_q <= sosc_d;
			cpu_q <= cpu_d;
			per_q <= per_d;
			fetch_q <= fetch_d;
			tbf_q <= tbf_d;
			fdiv_q <= fdiv_d;
			tb_q <= tb_d;
		end
	end

	dcpm_wdt #(
		.CYCLES_PER_MS (WDT_CYCLES_PER_MS)
	) u_wdt (
		.clock         (clock),
		.rst_n         (rst_sync_n),
		.sleeping      (sleeping),
		.wdt_reset_en  (ctrl.watchdog_reset_enable),
		.wake_int_en   (ctrl.wakeup_interrupt_enable),
		.period_sel    (ctrl.wdt_period_select),
		.clear_pulse   (watchdog_clear_instruction),
		.flag_clear    (wakeup_flag_clear),
		.osc_enable    (wdt_osc_enable),
		.chip_reset    (chip_reset_request),
		.wake_flag     (wakeup_timer_flag),
		.wake_event    (wkt_evt)
	);

	assign fast_osc_enable = fosc_q;
	assign slow_osc_enable = sosc_q;
	assign cpu_tick = cpu_q;
	assign periph_tick = per_q;
	assign cpu_fetch_enable = fetch_q;
	assign cpu_source = src_q;
	assign power_mode = mode_q;
	assign timebase_interrupt_flag = tbf_q;

	chk_start_fast_mode: assert property (@(posedge clock) disable iff (!rst_n) // RULE1
		$rose(rst_sync_n) |-> mode_q == dcpm_pkg::MODE_FAST && fast_osc_enable)
		else $error("controller left reset outside fast mode");

	chk_idle_entry: assert property (@(posedge clock) disable iff (!rst_sync_n) // RULE6
		(mode_q inside {dcpm_pkg::MODE_FAST, dcpm_pkg::MODE_SLOW})
		&& sleep_instruction && ctrl.slow_clock_enable
		|=> mode_q == dcpm_pkg::MODE_IDLE && !cpu_fetch_enable)
		else $error("sleep with slow clock did not enter idle");

	chk_stop_entry: assert property (@(posedge clock) disable iff (!rst_sync_n) // RULE7
		(mode_q inside {dcpm_pkg::MODE_FAST, dcpm_pkg::MODE_SLOW})
		&& sleep_instruction && !ctrl.slow_clock_enable
		|=> mode_q == dcpm_pkg::MODE_STOP && !fast_osc_enable && !slow_osc_enable)
		else $error("sleep without slow clock did not stop all oscillators");

	chk_stop_no_timebase: assert property (@(posedge clock) disable iff (!rst_sync_n) // RULE13
		mode_q == dcpm_pkg::MODE_STOP && !ext_w && !pb_w && !wkt_evt
		|=> mode_q == dcpm_pkg::MODE_STOP)
		else $error("stop mode left without a valid wake source");

	chk_sleep_only_entry: assert property (@(posedge clock) disable iff (!rst_sync_n) // RULE22
		(mode_q inside {dcpm_pkg::MODE_IDLE, dcpm_pkg::MODE_STOP})
		&& !($past(mode_q) inside {dcpm_pkg::MODE_IDLE, dcpm_pkg::MODE_STOP})
		|-> $past(sleep_instruction))
		else $error("power-down entered without sleep instruction");

	chk_periph_slow: assert property (@(posedge clock) disable iff (!rst_sync_n) // RULE5
		periph_tick && $past(mode_q) == dcpm_pkg::MODE_SLOW |-> $past(slow_edge))
		else $error("peripheral tick in slow mode not from slow clock");

	chk_timebase_flag: assert property (@(posedge clock) disable iff (!rst_sync_n) // RULE16
		tb_hit |=> timebase_interrupt_flag ##1 (timebase_interrupt_flag
			|| $past(timebase_flag_clear)))
		else $error("time-base flag not raised at selected ratio");

	chk_wake_stable: assert property (@(posedge clock) disable iff (!rst_sync_n) // RULE25
		$past(mode_q) == dcpm_pkg::MODE_WAKE && mode_q == dcpm_pkg::MODE_FAST
		|-> $past(fast_rdy) && !cpu_tick)
		else $error("fetch resumed before fast oscillator was ready");

	chk_switch_blank: assert property (@(posedge clock) disable iff (!rst_sync_n) // RULE24
		mode_q != $past(mode_q) |-> hold_q ##1 !cpu_tick)
		else $error("cpu tick passed during source changeover");

endmodule : dcpm_top

// [src/dcpm_wdt.sv]
// Shared watchdog and wake-up timer
`include "dcpm_map.svh"

module dcpm_wdt #(
	parameter int unsigned CYCLES_PER_MS = `DCPM_CYCLES_PER_MS
) (
	// Clock and reset
	input  wire logic clock,
	input  wire logic rst_n,
	// Control
	input  wire logic sleeping,
	input  wire logic wdt_reset_en,
	input  wire logic wake_int_en,
	input  wire logic period_sel,
	input  wire logic clear_pulse,
	input  wire logic flag_clear,
	// Results
	output logic      osc_enable,
	output logic      chip_reset,
	output logic      wake_flag,
	output logic      wake_event
);

	logic [15:0] pre_q, pre_d;
	logic [6:0]  ms_q, ms_d;
	logic        osc_q, osc_d;
	logic        rst_q, rst_d;
	logic        flag_q, flag_d;
	logic        evt_q, evt_d;
	logic        run, zap, pre_end, ovf;
	logic [6:0]  limit;

	always_comb
	begin
		run = sleeping ? wake_int_en : (wdt_reset_en | wake_int_en); // RULE20 RULE21
		zap = clear_pulse | (sleeping & wdt_reset_en & ~wake_int_en); // RULE18 RULE20
		limit = period_sel ? `DCPM_WDT_LONG_MS : `DCPM_WDT_SHORT_MS; // RULE17
		pre_end = (pre_q == 16'(CYCLES_PER_MS - 1));
		ovf = run & ~zap & pre_end & (ms_q == limit - 7'h01);
		pre_d = pre_q;
		ms_d = ms_q;
		if (zap)
		begin
			pre_d = 16'h0000;
			ms_d = 7'h00;
		end
		else if (run)
		begin
			pre_d = pre_end ? 16'h0000 : pre_q + 16'h0001;
			if (pre_end)
				ms_d = ovf ? 7'h00 : ms_q + 7'h01;
		end
		// Watchdog reset and wake-up timer exclude each other
		rst_d = ovf & wdt_reset_en; // RULE19 RULE23
		evt_d = ovf & ~wdt_reset_en; // RULE19 RULE23
		flag_d = evt_d | (flag_q & ~flag_clear);
		osc_d = run; // RULE21
	end

	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			pre_q <= 16'h0000;
			ms_q <= 7'h00;
			osc_q <= 1'h0;
			rst_q <= 1'h0;
			flag_q <= 1'h0;
			evt_q <= 1'h0;
		end
		else
		begin
			pre_q <= pre_d;
			ms_q <= ms_d;
			osc_q <= osc_d;
			rst_q <= rst_d;
			flag_q <= flag_d;
			evt_q <= evt_d;
		end
	end

	assign osc_enable = osc_q;
	assign chip_reset = rst_q;
	assign wake_flag = flag_q;
	assign wake_event = evt_q;

	chk_wdt_chip_reset: assert property (@(posedge clock) disable iff (!rst_n) // RULE19
		ovf && wdt_reset_en |=> chip_reset ##1 !chip_reset)
		else $error("watchdog overflow did not give one reset pulse");

	chk_wdt_clear_count: assert property (@(posedge clock) disable iff (!rst_n) // RULE18
		clear_pulse |=> (pre_q == 16'h0000) && (ms_q == 7'h00))
		else $error("clear instruction did not reset the timer");

	chk_wdt_sleep_hold: assert property (@(posedge clock) disable iff (!rst_n) // RULE20
		sleeping && !wake_int_en && !clear_pulse
		|=> $past(wdt_reset_en) ? (ms_q == 7'h00 && pre_q == 16'h0000)
			: ($stable(ms_q) && $stable(pre_q)))
		else $error("timer moved in sleep with wake-up disabled");

	chk_wdt_osc_normal: assert property (@(posedge clock) disable iff (!rst_n) // RULE21
		!sleeping |=> osc_enable == $past(wdt_reset_en | wake_int_en))
		else $error("watchdog oscillator wrong in normal mode");

endmodule : dcpm_wdt
